/* include/prbsuc_pkg.sv */
// Constants and carriers for the ungated pattern-checker error counters
package prbsuc_pkg;

    // Lane organisation
    localparam int PRBSUC_BANKS = 2;
    localparam int PRBSUC_LANES = 8;
    localparam int PRBSUC_NL = PRBSUC_BANKS * PRBSUC_LANES;
    localparam int PRBSUC_BANK_W = (PRBSUC_BANKS > 1) ? $clog2(PRBSUC_BANKS) : 1;
    localparam int PRBSUC_LANE_W = $clog2(PRBSUC_LANES);

    // Register byte offsets
    localparam int PRBSUC_ADDR_W = 8;
    localparam logic [7:0] PRBSUC_OFF_CTRL = 8'h00;
    localparam logic [7:0] PRBSUC_OFF_HOST_EN = 8'h04;
    localparam logic [7:0] PRBSUC_OFF_MEDIA_EN = 8'h08;
    localparam logic [7:0] PRBSUC_OFF_CAP = 8'h0C;
    localparam logic [7:0] PRBSUC_OFF_BANK = 8'h10;
    localparam logic [7:0] PRBSUC_OFF_SEL = 8'h14;
    localparam logic [7:0] PRBSUC_OFF_LANE = 8'h18;
    localparam logic [7:0] PRBSUC_OFF_DATA_LO = 8'h1C;
    localparam logic [7:0] PRBSUC_OFF_DATA_HI = 8'h20;
    localparam logic [7:0] PRBSUC_OFF_INT_STAT = 8'h24;
    localparam logic [7:0] PRBSUC_OFF_INT_MASK = 8'h28;

    // Control byte fields
    localparam int PRBSUC_CTRL_ALL_BIT = 7;
    localparam int PRBSUC_CTRL_RSTC_BIT = 5;
    localparam int PRBSUC_CTRL_AUTO_BIT = 4;
    localparam int PRBSUC_CTRL_GATE_LSB = 1;
    localparam int PRBSUC_GATE_W = 3;
    localparam int PRBSUC_CTRL_UPD_BIT = 0;
    localparam logic [7:0] PRBSUC_CTRL_RST = 8'h00;
    localparam logic [2:0] PRBSUC_GATE_OFF = 3'h0;

    // Capability and flag bits
    localparam int PRBSUC_CAP_RT_BIT = 4;
    localparam int PRBSUC_CAP_PLT_BIT = 3;
    localparam int PRBSUC_CAP_GDONE_BIT = 0;

    // Selector codes
    localparam logic [3:0] PRBSUC_SEL_H_ERR = 4'h1;
    localparam logic [3:0] PRBSUC_SEL_M_ERR = 4'h2;
    localparam logic [3:0] PRBSUC_SEL_H_BIT = 4'h3;
    localparam logic [3:0] PRBSUC_SEL_M_BIT = 4'h4;
    localparam logic [3:0] PRBSUC_PAGE_LIVE = 4'h0;
    localparam logic [3:0] PRBSUC_PAGE_LATCH = 4'h1;

    // Interrupt status bits
    localparam int PRBSUC_IRQ_W = 3;
    localparam int PRBSUC_IRQ_LATCH = 0;
    localparam int PRBSUC_IRQ_REFRESH = 1;
    localparam int PRBSUC_IRQ_CLEAR = 2;

    // Real-time refresh periods
    localparam int PRBSUC_CLK_HZ = 125_000_000;
    localparam int PRBSUC_UPD_SHORT_S = 1;
    localparam int PRBSUC_UPD_LONG_S = 5;
    localparam int unsigned PRBSUC_UPD_SHORT_CYC = PRBSUC_UPD_SHORT_S * PRBSUC_CLK_HZ;
    localparam int unsigned PRBSUC_UPD_LONG_CYC = PRBSUC_UPD_LONG_S * PRBSUC_CLK_HZ;

    // Per-side lane observations: error and bit-received pulses
    typedef struct packed {
        logic [PRBSUC_NL-1:0] err;
        logic [PRBSUC_NL-1:0] bits;
    } prbsuc_obs_t;

endpackage

/* design/prbsuc_top.sv */
`timescale 1ns/1ps
// Contract
// - Gate time zero: count continuously, auto-restart setting has no effect.
// - Newly enabled lanes zero all their counters and start counting.
// - Disabling a lane stops counting and presents results on both selector pages.
// - Without real-time capability, results appear only after disable or when reset-counters is set.
// - With real-time capability, live page refreshes periodically in ungated mode.
// - Reset-counters with all-lanes clear acts on enabled lanes of current bank.
// - Reset-counters with all-lanes set acts on enabled lanes of every bank.
// - Before an all-bank reset, previous results are copied to both pages.
// - After all-bank reset, live page restarts from zero, latched page keeps.
// - While reset-counters is one, enabled counters freeze and stay readable.
// - Reset-counters back to zero clears enabled host and media counters.
// - With one timer per side, the all-lanes bit is disregarded.
// - Update-interval bit picks one second or five seconds.
// - Ungated mode never raises the gate-complete flag.
// - Multi-word counter reads come from one sample.
module prbsuc_top
    import prbsuc_pkg::*;
#(
    parameter int CNT_W = 48,
    parameter int unsigned UPD_SHORT_CYC_P = PRBSUC_UPD_SHORT_CYC,
    parameter int unsigned UPD_LONG_CYC_P = PRBSUC_UPD_LONG_CYC,
    parameter bit RT_CAPABLE = 1'b1,
    parameter bit PER_LANE_TIMERS = 1'b1,
    parameter bit LATCH_IMPL = 1'b1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [PRBSUC_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire prbsuc_obs_t HOST_OBS,
    input wire prbsuc_obs_t MEDIA_OBS,
    output logic IRQ
);

    localparam int NL = PRBSUC_NL;

    // Software-visible state
    logic [7:0] ctrl_ff;
    logic [NL-1:0] en_ff [2];
    logic [NL-1:0] en_prev_ff [2];
    logic [PRBSUC_BANK_W-1:0] bank_ff;
    logic [7:0] sel_ff;
    logic [PRBSUC_LANE_W-1:0] lane_ff;
    logic [63:0] snap_ff;
    logic [31:0] prdata_ff;
    logic [PRBSUC_IRQ_W-1:0] stat_ff;
    logic [PRBSUC_IRQ_W-1:0] mask_ff;

    // Counter state, indexed [side][kind][lane]; kind 0 errors, 1 bits
    logic [CNT_W-1:0] cnt_ff [2][2][NL];
    logic [CNT_W-1:0] pub_ff [2][2][NL];
    logic [CNT_W-1:0] lat_ff [2][2][NL];

    // Reset-counters sequencing
    logic rc_prev_ff;
    logic [NL-1:0] scope_ff;
    logic [31:0] tick_cnt_ff;

    logic wr_acc;
    logic rd_setup;
    logic mapped;
    logic rc_rise;
    logic rc_fall;
    logic rc_on;
    logic ungated;
    logic all_scope;
    logic rt_tick;
    logic [31:0] period;
    logic [NL-1:0] bank_mask;
    logic [NL-1:0] scope_now;
    logic [NL-1:0] in_scope;
    logic [NL-1:0] clr_w [2];
    logic [NL-1:0] frz_w [2];
    logic [NL-1:0] cap_w [2];
    logic [NL-1:0] rise_w [2];
    logic [NL-1:0] fall_w [2];
    logic [NL-1:0] obs_err [2];
    logic [NL-1:0] obs_bit [2];
    logic [CNT_W-1:0] sample_val;
    logic [31:0] rd_word;
    logic [PRBSUC_IRQ_W-1:0] ev;

    // Bus strobes; every access completes in its first access cycle
    assign wr_acc = PSEL && PENABLE && PWRITE && PSTRB[0];
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign PREADY = PSEL && PENABLE;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = prdata_ff;
    assign IRQ = |(stat_ff & mask_ff);

    // Lane observations per side
    assign obs_err[0] = HOST_OBS.err;
    assign obs_bit[0] = HOST_OBS.bits;
    assign obs_err[1] = MEDIA_OBS.err;
    assign obs_bit[1] = MEDIA_OBS.bits;

    // Mode and scope decode
    assign ungated = ctrl_ff[PRBSUC_CTRL_GATE_LSB +: PRBSUC_GATE_W] == PRBSUC_GATE_OFF;
    assign rc_on = ctrl_ff[PRBSUC_CTRL_RSTC_BIT];
    assign rc_rise = rc_on && !rc_prev_ff;
    assign rc_fall = !rc_on && rc_prev_ff;
    assign all_scope = PER_LANE_TIMERS && ctrl_ff[PRBSUC_CTRL_ALL_BIT];
    assign bank_mask = NL'({PRBSUC_LANES{1'b1}}) << (int'(bank_ff) * PRBSUC_LANES);
    assign scope_now = all_scope ? {NL{1'b1}} : bank_mask;
    assign in_scope = rc_rise ? scope_now : scope_ff;

    // Per-lane enable edges and counter actions
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            rise_w[s] = en_ff[s] & ~en_prev_ff[s];
            fall_w[s] = ~en_ff[s] & en_prev_ff[s];
            clr_w[s] = rise_w[s] | ({NL{rc_fall}} & scope_ff & en_ff[s]);
            frz_w[s] = {NL{rc_on}} & in_scope & en_ff[s];
            cap_w[s] = fall_w[s] | ({NL{rc_rise}} & in_scope & en_ff[s]);
        end
    end

    // Refresh period select
    assign period = ctrl_ff[PRBSUC_CTRL_UPD_BIT] ? UPD_LONG_CYC_P : UPD_SHORT_CYC_P;
    assign rt_tick = tick_cnt_ff >= period - 32'h1;

    // Free-running refresh timer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tick_cnt_ff <= 32'h0;
        end else if (rt_tick) begin
            tick_cnt_ff <= 32'h0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end

    // Control, bank, selector and lane registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_ff <= PRBSUC_CTRL_RST;
            bank_ff <= '0;
            sel_ff <= 8'h00;
            lane_ff <= '0;
            mask_ff <= '0;
        end else if (wr_acc) begin
            unique case (PADDR)
                PRBSUC_OFF_CTRL: ctrl_ff <= PWDATA[7:0];
                PRBSUC_OFF_BANK: bank_ff <= PWDATA[PRBSUC_BANK_W-1:0];
                PRBSUC_OFF_SEL: sel_ff <= PWDATA[7:0];
                PRBSUC_OFF_LANE: lane_ff <= PWDATA[PRBSUC_LANE_W-1:0];
                PRBSUC_OFF_INT_MASK: mask_ff <= PWDATA[PRBSUC_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Enable bytes, paged by the current bank
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_ff[0] <= '0;
            en_ff[1] <= '0;
        end else if (wr_acc && PADDR == PRBSUC_OFF_HOST_EN) begin
            en_ff[0] <= (en_ff[0] & ~bank_mask)
                | (NL'(PWDATA[PRBSUC_LANES-1:0]) << (int'(bank_ff) * PRBSUC_LANES));
        end else if (wr_acc && PADDR == PRBSUC_OFF_MEDIA_EN) begin
            en_ff[1] <= (en_ff[1] & ~bank_mask)
                | (NL'(PWDATA[PRBSUC_LANES-1:0]) << (int'(bank_ff) * PRBSUC_LANES));
        end
    end

    // Edge history and reset-counters scope capture
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_prev_ff[0] <= '0;
            en_prev_ff[1] <= '0;
            rc_prev_ff <= 1'b0;
            scope_ff <= '0;
        end else begin
            en_prev_ff[0] <= en_ff[0];
            en_prev_ff[1] <= en_ff[1];
            rc_prev_ff <= rc_on;
            if (rc_rise) begin
                scope_ff <= scope_now;
            end
        end
    end

    // Counters, live page and latched page, one set per side and lane
    for (genvar s = 0; s < 2; s++) begin : g_side
        for (genvar l = 0; l < NL; l++) begin : g_lane
            // Accumulation: cleared, frozen or counting
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    cnt_ff[s][0][l] <= '0;
                    cnt_ff[s][1][l] <= '0;
                end else if (clr_w[s][l]) begin
                    cnt_ff[s][0][l] <= '0;
                    cnt_ff[s][1][l] <= '0;
                end else if (en_ff[s][l] && !frz_w[s][l]) begin
                    cnt_ff[s][0][l] <= cnt_ff[s][0][l] + CNT_W'(obs_err[s][l]);
                    cnt_ff[s][1][l] <= cnt_ff[s][1][l] + CNT_W'(obs_bit[s][l]);
                end
            end

            // Live page: restart, capture, or periodic refresh
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    pub_ff[s][0][l] <= '0;
                    pub_ff[s][1][l] <= '0;
                end else if (clr_w[s][l]) begin
                    pub_ff[s][0][l] <= '0;
                    pub_ff[s][1][l] <= '0;
                end else if (cap_w[s][l]) begin
                    pub_ff[s][0][l] <= cnt_ff[s][0][l];
                    pub_ff[s][1][l] <= cnt_ff[s][1][l];
                end else if (RT_CAPABLE && ungated && rt_tick && en_ff[s][l]
                        && !frz_w[s][l]) begin
                    pub_ff[s][0][l] <= cnt_ff[s][0][l];
                    pub_ff[s][1][l] <= cnt_ff[s][1][l];
                end
            end

            // Latched page keeps the previous period across a restart
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    lat_ff[s][0][l] <= '0;
                    lat_ff[s][1][l] <= '0;
                end else if (LATCH_IMPL && cap_w[s][l]) begin
                    lat_ff[s][0][l] <= cnt_ff[s][0][l];
                    lat_ff[s][1][l] <= cnt_ff[s][1][l];
                end
            end
        end
    end

    // Selector decode to one counter value
    always_comb begin
        int idx;
        int side;
        int kind;
        logic live;
        logic latch;
        idx = int'(bank_ff) * PRBSUC_LANES + int'(lane_ff);
        side = (sel_ff[3:0] == PRBSUC_SEL_M_ERR || sel_ff[3:0] == PRBSUC_SEL_M_BIT) ? 1 : 0;
        kind = (sel_ff[3:0] == PRBSUC_SEL_H_BIT || sel_ff[3:0] == PRBSUC_SEL_M_BIT) ? 1 : 0;
        live = sel_ff[7:4] == PRBSUC_PAGE_LIVE;
        latch = LATCH_IMPL && sel_ff[7:4] == PRBSUC_PAGE_LATCH;
        sample_val = '0;
        if (sel_ff[3:0] >= PRBSUC_SEL_H_ERR && sel_ff[3:0] <= PRBSUC_SEL_M_BIT) begin
            if (live) begin
                sample_val = pub_ff[side][kind][idx];
            end else if (latch) begin
                sample_val = lat_ff[side][kind][idx];
            end
        end
    end

    // Read mux and address map
    always_comb begin
        rd_word = 32'h0;
        mapped = 1'b1;
        unique case (PADDR)
            PRBSUC_OFF_CTRL: rd_word = {24'h0, ctrl_ff};
            PRBSUC_OFF_HOST_EN: rd_word = 32'(en_ff[0] >> (int'(bank_ff) * PRBSUC_LANES)) & 32'hFF;
            PRBSUC_OFF_MEDIA_EN: rd_word = 32'(en_ff[1] >> (int'(bank_ff) * PRBSUC_LANES)) & 32'hFF;
            PRBSUC_OFF_CAP: begin
                rd_word[PRBSUC_CAP_RT_BIT] = RT_CAPABLE;
                rd_word[PRBSUC_CAP_PLT_BIT] = PER_LANE_TIMERS;
                rd_word[PRBSUC_CAP_GDONE_BIT] = !ungated && 1'b0;
            end
            PRBSUC_OFF_BANK: rd_word = 32'(bank_ff);
            PRBSUC_OFF_SEL: rd_word = {24'h0, sel_ff};
            PRBSUC_OFF_LANE: rd_word = 32'(lane_ff);
            PRBSUC_OFF_DATA_LO: rd_word = sample_val[31:0];
            PRBSUC_OFF_DATA_HI: rd_word = snap_ff[63:32];
            PRBSUC_OFF_INT_STAT: rd_word = 32'(stat_ff);
            PRBSUC_OFF_INT_MASK: rd_word = 32'(mask_ff);
            default: mapped = 1'b0;
        endcase
    end

    // Read data and coherent snapshot, loaded in the setup cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prdata_ff <= 32'h0;
            snap_ff <= 64'h0;
        end else if (rd_setup) begin
            prdata_ff <= rd_word;
            if (PADDR == PRBSUC_OFF_DATA_LO) begin
                snap_ff <= 64'(sample_val);
            end
        end
    end

    // Interrupt events: results latched, live refresh, counters cleared
    assign ev[PRBSUC_IRQ_LATCH] = |cap_w[0] || |cap_w[1];
    assign ev[PRBSUC_IRQ_REFRESH] = RT_CAPABLE && ungated && rt_tick && (|en_ff[0] || |en_ff[1]);
    assign ev[PRBSUC_IRQ_CLEAR] = |clr_w[0] || |clr_w[1];

    // Sticky status, write one to clear, set wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stat_ff <= '0;
        end else if (wr_acc && PADDR == PRBSUC_OFF_INT_STAT) begin
            stat_ff <= (stat_ff & ~PWDATA[PRBSUC_IRQ_W-1:0]) | ev;
        end else begin
            stat_ff <= stat_ff | ev;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_enable_clears: assert property (rise_w[0][0] |=> cnt_ff[0][0][0] == '0
        && pub_ff[0][0][0] == '0) else $error("enable did not clear counter");
    a_disable_latch: assert property (fall_w[0][0] |=> pub_ff[0][0][0] == $past(cnt_ff[0][0][0])
        && !en_ff[0][0] || $stable(cnt_ff[0][0][0])) else $error("disable did not present result");
    a_no_rt_stable: assert property ((!RT_CAPABLE || !ungated) && !clr_w[0][0] && !cap_w[0][0]
        |=> $stable(pub_ff[0][0][0])) else $error("live page changed without cause");
    a_rt_refresh: assert property (RT_CAPABLE && ungated && rt_tick && en_ff[0][0]
        && !clr_w[0][0] && !cap_w[0][0] && !frz_w[0][0]
        |=> pub_ff[0][0][0] == $past(cnt_ff[0][0][0])) else $error("refresh missed");
    a_tick_period: assert property (rt_tick && $stable(period)
        |-> tick_cnt_ff == period - 32'h1 ##1 tick_cnt_ff == 32'h0)
        else $error("refresh period wrong");
    a_scope_select: assert property (rc_rise && bank_ff != '0 && en_ff[0][0]
        |=> frz_w[0][0] == (PER_LANE_TIMERS && ctrl_ff[PRBSUC_CTRL_ALL_BIT]) || !rc_on)
        else $error("reset scope wrong");
    a_allbank_copy: assert property (rc_rise && en_ff[0][0] && in_scope[0] && LATCH_IMPL
        |=> lat_ff[0][0][0] == $past(cnt_ff[0][0][0])) else $error("latched page not copied");
    a_freeze_hold: assert property (frz_w[0][0] && !clr_w[0][0]
        |=> $stable(cnt_ff[0][0][0])) else $error("frozen counter moved");
    a_release_zero: assert property (rc_fall && scope_ff[0] && en_ff[1][0]
        |=> cnt_ff[1][1][0] == '0 && pub_ff[1][1][0] == '0) else $error("release did not clear");
    a_latch_kept: assert property (rc_fall && scope_ff[0] && en_ff[0][0]
        |=> $stable(lat_ff[0][0][0])) else $error("latched page lost on restart");

endmodule

/* verification/prbsuc_host_model.sv */
`timescale 1ns/1ps
// Management controller: APB master, one transfer at a time
module prbsuc_host_model
    import prbsuc_pkg::*;
(
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [PRBSUC_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic last_err;

    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        last_err = 1'b0;
    end

    // Setup, access held until ready, then release at that edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* verification/prbs_checker_ungated_error_counters_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the ungated error counters
module prbs_checker_ungated_error_counters_bench;
    import prbsuc_pkg::*;
    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic use_b;
    logic [31:0] prdata_b;
    logic pready_b;
    logic pslverr_b;
    logic [31:0] prdata_m;
    logic pready_m;
    logic pslverr_m;
    prbsuc_obs_t ho;
    prbsuc_obs_t mo;
    int errors = 0;
    int num_checks = 0;
    localparam logic [31:0] CAP_EXP = (32'h1 << PRBSUC_CAP_RT_BIT) | (32'h1 << PRBSUC_CAP_PLT_BIT);

    // Design with short refresh periods
    prbsuc_top #(.UPD_SHORT_CYC_P(20), .UPD_LONG_CYC_P(100)) i_prbsuc_top (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .HOST_OBS(ho), .MEDIA_OBS(mo), .IRQ(irq));

    // Second build: no real-time update, one timer per side
    prbsuc_top #(.UPD_SHORT_CYC_P(20), .UPD_LONG_CYC_P(100), .RT_CAPABLE(1'b0),
        .PER_LANE_TIMERS(1'b0)) i_prbsuc_top_b (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata_b),
        .PREADY(pready_b), .PSLVERR(pslverr_b), .HOST_OBS(ho), .MEDIA_OBS(mo), .IRQ());

    // Read path from the build under test
    assign prdata_m = use_b ? prdata_b : prdata;
    assign pready_m = use_b ? pready_b : pready;
    assign pslverr_m = use_b ? pslverr_b : pslverr;

    prbsuc_host_model i_prbsuc_host_model (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata_m), .pready(pready_m), .pslverr(pslverr_m));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_prbsuc_host_model.xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        i_prbsuc_host_model.xfer(1'b0, a, 32'h0, q);
    endtask

    // Selects page, bank and lane, then reads low word before high word
    task automatic rdcnt(input logic [7:0] sel, input logic [31:0] bank, input logic [31:0] lane,
                         input logic [63:0] exp, input string nm);
        logic [31:0] lo;
        logic [31:0] hi;
        wr(PRBSUC_OFF_BANK, bank);
        wr(PRBSUC_OFF_SEL, sel);
        wr(PRBSUC_OFF_LANE, lane);
        rd(PRBSUC_OFF_DATA_LO, lo);
        rd(PRBSUC_OFF_DATA_HI, hi);
        chk(nm, {hi, lo}, exp);
    endtask

    // Error and bit pulses for n cycles on the masked lanes
    task automatic pulse(input bit med, input logic [15:0] m, input int n);
        @(posedge clk);
        if (med) mo <= {m, m};
        else ho <= {m, m};
        wt(n);
        ho <= '0;
        mo <= '0;
        wt(3);
    endtask

    task automatic t_regs;
        logic [31:0] q;
        rd(PRBSUC_OFF_CTRL, q);
        chk("ctrl reset", q, 64'h0);
        wr(PRBSUC_OFF_CAP, 32'hFF);
        rd(PRBSUC_OFF_CAP, q);
        chk("capability", q, CAP_EXP);
        rd(8'hFC, q);
        chk("unmapped data", q, 64'h0);
        chk("unmapped error", i_prbsuc_host_model.last_err, 64'h1);
        $display("done: registers");
    endtask

    task automatic t_count;
        wr(PRBSUC_OFF_CTRL, 32'h10);
        wr(PRBSUC_OFF_BANK, 32'h0);
        wr(PRBSUC_OFF_HOST_EN, 32'h1);
        wt(3);
        pulse(1'b0, 16'h0001, 6);
        wr(PRBSUC_OFF_HOST_EN, 32'h0);
        wt(3);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 0, 0, 6, "live err");
        rdcnt({PRBSUC_PAGE_LATCH, PRBSUC_SEL_H_ERR}, 0, 0, 6, "latched err");
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_BIT}, 0, 0, 6, "live bits");
        wr(PRBSUC_OFF_HOST_EN, 32'h1);
        wt(3);
        wr(PRBSUC_OFF_HOST_EN, 32'h0);
        wt(3);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 0, 0, 0, "restart err");
        $display("done: enable and disable");
    endtask

    task automatic t_refresh;
        logic [31:0] q;
        wr(PRBSUC_OFF_CTRL, 32'h0);
        wr(PRBSUC_OFF_MEDIA_EN, 32'h1);
        wt(3);
        pulse(1'b1, 16'h0001, 5);
        wt(25);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_M_ERR}, 0, 0, 5, "short refresh");
        wr(PRBSUC_OFF_CTRL, 32'h1);
        // Wait for a long-period refresh, then count between two refreshes
        wr(PRBSUC_OFF_INT_STAT, 32'h1 << PRBSUC_IRQ_REFRESH);
        q = 32'h0;
        while (q[PRBSUC_IRQ_REFRESH] !== 1'b1) rd(PRBSUC_OFF_INT_STAT, q);
        pulse(1'b1, 16'h0001, 4);
        wt(10);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_M_ERR}, 0, 0, 5, "held between refreshes");
        wt(100);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_M_ERR}, 0, 0, 9, "long refresh");
        wr(PRBSUC_OFF_MEDIA_EN, 32'h0);
        $display("done: refresh");
    endtask

    task automatic t_reset;
        wr(PRBSUC_OFF_CTRL, 32'h0);
        wr(PRBSUC_OFF_BANK, 32'h0);
        wr(PRBSUC_OFF_HOST_EN, 32'h1);
        wr(PRBSUC_OFF_BANK, 32'h1);
        wr(PRBSUC_OFF_HOST_EN, 32'h1);
        wt(3);
        pulse(1'b0, 16'h0101, 4);
        wr(PRBSUC_OFF_CTRL, 32'hA0);
        wt(3);
        pulse(1'b0, 16'h0101, 3);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 1, 0, 4, "frozen live");
        rdcnt({PRBSUC_PAGE_LATCH, PRBSUC_SEL_H_ERR}, 0, 0, 4, "copied latch");
        wr(PRBSUC_OFF_CTRL, 32'h80);
        wt(3);
        pulse(1'b0, 16'h0100, 2);
        wt(25);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 0, 0, 0, "cleared bank0");
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 1, 0, 2, "restart bank1");
        rdcnt({PRBSUC_PAGE_LATCH, PRBSUC_SEL_H_ERR}, 0, 0, 4, "kept latch");
        wr(PRBSUC_OFF_BANK, 32'h0);
        wr(PRBSUC_OFF_CTRL, 32'h20);
        wt(3);
        wr(PRBSUC_OFF_CTRL, 32'h0);
        wt(3);
        pulse(1'b0, 16'h0101, 1);
        wr(PRBSUC_OFF_HOST_EN, 32'h0);
        wr(PRBSUC_OFF_BANK, 32'h1);
        wr(PRBSUC_OFF_HOST_EN, 32'h0);
        wt(3);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 0, 0, 1, "bank scope b0");
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 1, 0, 3, "bank scope b1");
        $display("done: reset counters");
    endtask

    // Latch event raises, masks and clears the interrupt
    task automatic t_irq;
        logic [31:0] q;
        wr(PRBSUC_OFF_INT_STAT, 32'h7);
        wr(PRBSUC_OFF_INT_MASK, 32'h1 << PRBSUC_IRQ_LATCH);
        wt(1);
        chk("irq idle", irq, 64'h0);
        wr(PRBSUC_OFF_HOST_EN, 32'h1);
        wt(3);
        wr(PRBSUC_OFF_HOST_EN, 32'h0);
        wt(3);
        chk("irq raised", irq, 64'h1);
        rd(PRBSUC_OFF_INT_STAT, q);
        chk("latch status", q[PRBSUC_IRQ_LATCH], 64'h1);
        wr(PRBSUC_OFF_INT_STAT, 32'h1 << PRBSUC_IRQ_LATCH);
        wt(1);
        chk("irq cleared", irq, 64'h0);
        wr(PRBSUC_OFF_INT_MASK, 32'h0);
        wr(PRBSUC_OFF_HOST_EN, 32'h1);
        wt(3);
        wr(PRBSUC_OFF_HOST_EN, 32'h0);
        wt(3);
        chk("irq masked", irq, 64'h0);
        $display("done: interrupt");
    endtask

    // Build without real-time update and with one timer per side
    task automatic t_variant;
        use_b <= 1'b1;
        wr(PRBSUC_OFF_CTRL, 32'h0);
        wr(PRBSUC_OFF_BANK, 32'h0);
        wr(PRBSUC_OFF_HOST_EN, 32'h1);
        wr(PRBSUC_OFF_MEDIA_EN, 32'h1);
        wr(PRBSUC_OFF_BANK, 32'h1);
        wr(PRBSUC_OFF_HOST_EN, 32'h1);
        wt(3);
        pulse(1'b0, 16'h0101, 4);
        wt(25);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 1, 0, 0, "no live refresh");
        wr(PRBSUC_OFF_CTRL, 32'hA0);
        wt(3);
        pulse(1'b0, 16'h0101, 2);
        wr(PRBSUC_OFF_CTRL, 32'h0);
        wt(3);
        pulse(1'b0, 16'h0101, 1);
        wr(PRBSUC_OFF_HOST_EN, 32'h0);
        wr(PRBSUC_OFF_BANK, 32'h0);
        wr(PRBSUC_OFF_HOST_EN, 32'h0);
        wr(PRBSUC_OFF_MEDIA_EN, 32'h0);
        wt(3);
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 0, 0, 7, "all bit ignored");
        rdcnt({PRBSUC_PAGE_LIVE, PRBSUC_SEL_H_ERR}, 1, 0, 1, "result on disable");
        use_b <= 1'b0;
        $display("done: variant build");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #400000;
        errors++;
        final_report();
    end

    // Reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        use_b = 1'b0;
        ho = '0;
        mo = '0;
        wt(8);
        rst <= 1'b0;
        t_regs();
        t_count();
        t_refresh();
        t_reset();
        t_irq();
        t_variant();
        final_report();
    end
endmodule
